/* File: rtl/mirror_ctrl_regs.svh */
`ifndef MIRROR_CTRL_REGS_SVH
`define MIRROR_CTRL_REGS_SVH

// Register port word indices.
`define REG_CTRL        4'h0
`define REG_DRIVER      4'h1
`define REG_IRQ_STATUS  4'h2
`define REG_IRQ_ENABLE  4'h3
`define REG_IRQ_CLEAR   4'h4
`define REG_SERIAL_RX   4'h5
`define REG_SERIAL_TX   4'h6

// Control register fields.
`define CTRL_BIAS_BIT    0
`define CTRL_OFFSET_BIT  1
`define CTRL_NEG_BIT     2
`define CTRL_W           3
`define CTRL_RST         3'h0

// Interrupt status, enable and clear layout.
`define IRQ_STROBE_BIT   0
`define IRQ_CLEAR_BIT    1
`define IRQ_SERIAL_BIT   2
`define IRQ_W            3
`define IRQ_RST          3'h0

// Serial port word.
`define SER_W            8
`define SER_LAST_BIT     3'h7
`define SER_RST          8'h00

// Pin synchroniser vector width and its pull levels: only the output enable pulls up.
`define PIN_W            14
`define PIN_PULL_RST     14'h0800

`endif

/* File: rtl/mirror_ctrl_pkg.sv */
`default_nettype none
package mirror_ctrl_pkg;

  typedef logic [3:0]  reg_addr_t;
  typedef logic [15:0] reg_data_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0] mode;
    logic [3:0] addr;
  } driver_cmd_s;

  typedef struct packed {
    logic        strobe;
    logic        clear_n;
    logic        oe_n;
    logic        sclk;
    logic        sdi;
    logic        sen_n;
    driver_cmd_s cmd;
  } pin_in_s;

  typedef enum logic {
    FRAME_IDLE,
    FRAME_ACTIVE
  } frame_state_e;

endpackage
`default_nettype wire

/* File: rtl/pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Asynchronous pins in, synchronised levels out.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // The first stage feeds only the second stage.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        meta_r[i] <= RST_VAL[i];
        q_r[i]    <= RST_VAL[i];
      end else begin
        meta_r[i] <= d[i];
        q_r[i]    <= meta_r[i];
      end
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

/* File: rtl/micromirror_reset_control_port.sv */
// Overview of operation
// - Address, mode and level are captured on strobe rising edges and held.
// - Driver address select is four bits choosing the targeted reset driver.
// - Driver mode select is two bits captured with the other controls.
// - Driver level select is two bits choosing the addressed driver level.
// - Driver outputs are enabled only while the output enable input is low.
// - An undriven output enable reads high, keeping driver outputs disabled.
// - Address, mode, level, strobe and clear inputs read low when undriven.
// - While clear is low all driver circuitry is forced to the offset state.
// - Serial clock only counts while serial enable is low.
// - Serial input data are sampled on serial clock rising edges.
// - Serial read data return on the serial output during enabled transfers.
// - Three active-high enables switch the bias, offset and negative regulators.
// - Interrupt output is driven low while an interrupt is pending; here only a pending source whose enable bit is set drives it low.
//
// Chosen here: strobed register access and the address map.
`include "mirror_ctrl_regs.svh"
`default_nettype none
module micromirror_reset_control_port (
  // System.
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  // Register port.
  input  wire mirror_ctrl_pkg::reg_addr_t reg_addr,
  input  wire mirror_ctrl_pkg::reg_data_t reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output mirror_ctrl_pkg::reg_data_t    reg_rdata,
  // Reset driver control pins.
  input  wire logic [3:0]               driver_address,
  input  wire logic [1:0]               driver_mode,
  input  wire logic [1:0]               driver_level_select,
  input  wire logic                     driver_strobe,
  input  wire logic                     driver_output_enable_n,
  input  wire logic                     driver_clear_n,
  // Serial port pins.
  input  wire logic                     serial_port_clock,
  input  wire logic                     serial_port_data_in,
  input  wire logic                     serial_port_enable_n,
  output logic                          serial_port_data_out,
  // Reset driver state.
  output mirror_ctrl_pkg::driver_cmd_s  driver_cmd,
  output logic                          driver_outputs_on,
  output logic                          driver_offset_hold,
  // Regulator enables.
  output logic                          bias_supply_level_en,
  output logic                          offset_supply_level_en,
  output logic                          negative_supply_level_en,
  // Interrupt.
  output logic                          driver_interrupt_n
);

  import mirror_ctrl_pkg::*;

  pin_in_s pin_raw;
  pin_in_s pin_s;
  logic [`PIN_W-1:0] pin_bits;

  assign pin_raw = {driver_strobe, driver_clear_n, driver_output_enable_n, serial_port_clock,
                    serial_port_data_in, serial_port_enable_n, driver_level_select, driver_mode,
                    driver_address};

  // Synchroniser flops come out of reset at the pad pull levels.
  pin_sync #(
    .WIDTH   (`PIN_W),
    .RST_VAL (`PIN_PULL_RST)
  ) u_pin_sync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (pin_raw),
    .q     (pin_bits)
  );

  assign pin_s = pin_bits;

  // Edge history of the synchronised pins.
  logic strobe_q_r;
  logic sclk_q_r;
  logic sen_n_q_r;
  logic clear_q_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q_r <= 1'b0;
      sclk_q_r   <= 1'b0;
      sen_n_q_r  <= 1'b0;
      clear_q_r  <= 1'b0;
    end else begin
      strobe_q_r <= pin_s.strobe;
      sclk_q_r   <= pin_s.sclk;
      sen_n_q_r  <= pin_s.sen_n;
      clear_q_r  <= pin_s.clear_n;
    end
  end

  logic strobe_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sen_fall;
  logic clear_fall;

  assign strobe_rise = pin_s.strobe & ~strobe_q_r;
  assign sclk_rise   = pin_s.sclk & ~sclk_q_r;
  assign sclk_fall   = ~pin_s.sclk & sclk_q_r;
  assign sen_fall    = ~pin_s.sen_n & sen_n_q_r;
  assign clear_fall  = ~pin_s.clear_n & clear_q_r;

  // Reset driver latch.
  driver_cmd_s cmd_r;
  driver_cmd_s cmd_nxt;
  logic        on_r;
  logic        on_nxt;
  logic        hold_r;
  logic        hold_nxt;

  always_comb begin
    cmd_nxt  = cmd_r;
    hold_nxt = ~pin_s.clear_n;
    on_nxt   = ~pin_s.oe_n & pin_s.clear_n;
    if (!pin_s.clear_n) begin
      cmd_nxt = '0;
    end else if (strobe_rise) begin
      cmd_nxt = pin_s.cmd;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r  <= '0;
      on_r   <= 1'b0;
      hold_r <= 1'b1;
    end else begin
      cmd_r  <= cmd_nxt;
      on_r   <= on_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Serial port engine.
  frame_state_e     state_r;
  frame_state_e     state_nxt;
  logic [2:0]       bit_cnt_r;
  logic [2:0]       bit_cnt_nxt;
  logic [`SER_W-1:0] rx_shift_r;
  logic [`SER_W-1:0] rx_shift_nxt;
  logic [`SER_W-1:0] rx_word_r;
  logic [`SER_W-1:0] rx_word_nxt;
  logic [`SER_W-1:0] tx_shift_r;
  logic [`SER_W-1:0] tx_shift_nxt;
  logic             reload_r;
  logic             reload_nxt;
  logic             sdo_r;
  logic             sdo_nxt;
  logic             rx_done;
  logic [`SER_W-1:0] tx_reg_r;

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    rx_shift_nxt = rx_shift_r;
    rx_word_nxt  = rx_word_r;
    tx_shift_nxt = tx_shift_r;
    reload_nxt   = reload_r;
    rx_done      = 1'b0;
    case (state_r)
      FRAME_IDLE: begin
        // Clock edges outside a frame are ignored.
        if (sen_fall) begin
          state_nxt    = FRAME_ACTIVE;
          bit_cnt_nxt  = 3'h0;
          tx_shift_nxt = tx_reg_r;
          reload_nxt   = 1'b0;
        end
      end
      FRAME_ACTIVE: begin
        if (pin_s.sen_n) begin
          state_nxt = FRAME_IDLE;
        end else if (sclk_rise) begin
          rx_shift_nxt = {rx_shift_r[`SER_W-2:0], pin_s.sdi};
          bit_cnt_nxt  = bit_cnt_r + 3'h1;
          if (bit_cnt_r == `SER_LAST_BIT) begin
            rx_word_nxt = {rx_shift_r[`SER_W-2:0], pin_s.sdi};
            rx_done     = 1'b1;
            reload_nxt  = 1'b1;
          end
        end else if (sclk_fall) begin
          // Shifting on the falling edge gives the controller half a period of setup.
          tx_shift_nxt = reload_r ? tx_reg_r : {tx_shift_r[`SER_W-2:0], 1'b0};
          reload_nxt   = 1'b0;
        end
      end
      default: begin
        state_nxt = FRAME_IDLE;
      end
    endcase
    sdo_nxt = (state_nxt == FRAME_ACTIVE) ? tx_shift_nxt[`SER_W-1] : 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= FRAME_IDLE;
      bit_cnt_r  <= 3'h0;
      rx_shift_r <= `SER_RST;
      rx_word_r  <= `SER_RST;
      tx_shift_r <= `SER_RST;
      reload_r   <= 1'b0;
      sdo_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_word_r  <= rx_word_nxt;
      tx_shift_r <= tx_shift_nxt;
      reload_r   <= reload_nxt;
      sdo_r      <= sdo_nxt;
    end
  end

  // Register file and interrupts.
  logic [`CTRL_W-1:0] ctrl_r;
  logic [`CTRL_W-1:0] ctrl_nxt;
  logic [`IRQ_W-1:0]  irq_en_r;
  logic [`IRQ_W-1:0]  irq_en_nxt;
  logic [`IRQ_W-1:0]  irq_stat_r;
  logic [`IRQ_W-1:0]  irq_stat_nxt;
  logic [`IRQ_W-1:0]  irq_set;
  logic [`IRQ_W-1:0]  irq_clr;
  logic [`SER_W-1:0]  tx_reg_nxt;
  reg_data_t          rdata_r;
  reg_data_t          rdata_nxt;
  logic               irq_n_r;
  logic               irq_n_nxt;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    irq_en_nxt = irq_en_r;
    tx_reg_nxt = tx_reg_r;
    irq_clr    = '0;
    rdata_nxt  = '0;
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL:       ctrl_nxt   = reg_wdata[`CTRL_W-1:0];
        `REG_IRQ_ENABLE: irq_en_nxt = reg_wdata[`IRQ_W-1:0];
        `REG_IRQ_CLEAR:  irq_clr    = reg_wdata[`IRQ_W-1:0];
        `REG_SERIAL_TX:  tx_reg_nxt = reg_wdata[`SER_W-1:0];
        default:         ctrl_nxt   = ctrl_r;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:       rdata_nxt = {13'h0000, ctrl_r};
        `REG_DRIVER:     rdata_nxt = {6'h00, hold_r, on_r, cmd_r};
        `REG_IRQ_STATUS: rdata_nxt = {13'h0000, irq_stat_r};
        `REG_IRQ_ENABLE: rdata_nxt = {13'h0000, irq_en_r};
        `REG_SERIAL_RX:  rdata_nxt = {8'h00, rx_word_r};
        `REG_SERIAL_TX:  rdata_nxt = {8'h00, tx_reg_r};
        default:         rdata_nxt = 16'h0000;
      endcase
    end
    irq_set = '0;
    irq_set[`IRQ_STROBE_BIT] = strobe_rise & pin_s.clear_n;
    irq_set[`IRQ_CLEAR_BIT]  = clear_fall;
    irq_set[`IRQ_SERIAL_BIT] = rx_done;
    // A new event outranks a clear written in the same cycle.
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    irq_n_nxt    = ~|(irq_stat_nxt & irq_en_nxt);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r     <= `CTRL_RST;
      irq_en_r   <= `IRQ_RST;
      irq_stat_r <= `IRQ_RST;
      tx_reg_r   <= `SER_RST;
      rdata_r    <= 16'h0000;
      irq_n_r    <= 1'b1;
    end else begin
      ctrl_r     <= ctrl_nxt;
      irq_en_r   <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      tx_reg_r   <= tx_reg_nxt;
      rdata_r    <= rdata_nxt;
      irq_n_r    <= irq_n_nxt;
    end
  end

  assign reg_rdata                = rdata_r;
  assign serial_port_data_out     = sdo_r;
  assign driver_cmd               = cmd_r;
  assign driver_outputs_on        = on_r;
  assign driver_offset_hold       = hold_r;
  assign bias_supply_level_en     = ctrl_r[`CTRL_BIAS_BIT];
  assign offset_supply_level_en   = ctrl_r[`CTRL_OFFSET_BIT];
  assign negative_supply_level_en = ctrl_r[`CTRL_NEG_BIT];
  assign driver_interrupt_n       = irq_n_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_strobe_capture;
    (strobe_rise && pin_s.clear_n) |=> (cmd_r == $past(pin_s.cmd));
  endproperty
  a_strobe_capture: assert property (p_strobe_capture) else $error("strobe did not capture controls");

  property p_cmd_hold;
    (!strobe_rise && pin_s.clear_n) |=> (cmd_r == $past(cmd_r));
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("driver controls changed without strobe");

  property p_oe_off;
    pin_s.oe_n |=> !driver_outputs_on;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driver outputs on while enable high");

  property p_clear;
    !pin_s.clear_n |=> (driver_offset_hold && cmd_r == '0 && !driver_outputs_on);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not force offset state");

  property p_sample;
    (state_r == FRAME_ACTIVE && !pin_s.sen_n && sclk_rise && bit_cnt_r == `SER_LAST_BIT)
      |=> (rx_word_r == {$past(rx_shift_r[`SER_W-2:0]), $past(pin_s.sdi)});
  endproperty
  a_sample: assert property (p_sample) else $error("serial word sampled wrongly");

  property p_idle_sclk;
    (state_r == FRAME_IDLE && !sen_fall) |=> (bit_cnt_r == $past(bit_cnt_r) && state_r == FRAME_IDLE);
  endproperty
  a_idle_sclk: assert property (p_idle_sclk) else $error("serial clock counted outside frame");

  property p_sdo_idle;
    (state_r == FRAME_IDLE) |-> !serial_port_data_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial output driven outside frame");

  property p_sdo_fall;
    (state_r == FRAME_ACTIVE && !pin_s.sen_n && !sclk_fall) |=> $stable(serial_port_data_out);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("serial output moved off a falling edge");

  property p_regulator;
    (reg_wr && reg_addr == `REG_CTRL)
      |=> (negative_supply_level_en == $past(reg_wdata[`CTRL_NEG_BIT]) && bias_supply_level_en == $past(reg_wdata[0]));
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator enable not written");

  property p_irq;
    ##1 (driver_interrupt_n == !(|(irq_stat_r & irq_en_r)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output disagrees with status");

  property p_set_wins;
    (rx_done && reg_wr && reg_addr == `REG_IRQ_CLEAR) |=> irq_stat_r[`IRQ_SERIAL_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to a clear");

  property p_rdata_zero;
    !reg_rd |=> (reg_rdata == 16'h0000);
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside read slot");

  c_strobe: cover property (strobe_rise && pin_s.clear_n);
  c_word:   cover property (rx_done);
  c_irq:    cover property ($fell(driver_interrupt_n));

endmodule
`default_nettype wire

/* File: tb/ctrl_model.sv */
`default_nettype none
module ctrl_model
  import mirror_ctrl_pkg::*;
(
  // Clock.
  input  wire logic         clk,
  // Pins towards the device.
  output var driver_cmd_s   cmd,
  output var logic          strobe,
  output var logic          oe_n,
  output var logic          clear_n,
  output var logic          sclk,
  output var logic          sdi,
  output var logic          sen_n,
  // Serial reply.
  input  wire logic         sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins start at their pull levels, as an unpowered controller would leave them, except serial enable, which starts high.
  initial begin
    cmd     = '0;
    strobe  = 1'b0;
    clear_n = 1'b0;
    oe_n    = 1'b1;
    sclk    = 1'b0;
    sdi     = 1'b0;
    sen_n   = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic set_cmd(input driver_cmd_s c);
    wait_clk(1);
    cmd <= c;
  endtask

  // Controls stay put for four cycles on each side of the rising strobe.
  task automatic send_cmd(input driver_cmd_s c);
    set_cmd(c);
    wait_clk(4);
    strobe <= 1'b1;
    wait_clk(4);
    strobe <= 1'b0;
    wait_clk(4);
  endtask

  task automatic set_pins(input logic oe, input logic clr);
    wait_clk(1);
    oe_n    <= oe;
    clear_n <= clr;
  endtask

  // One word, MSB first; half is the clock half period in system cycles.
  task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
    int i;
    wait_clk(1);
    sen_n <= 1'b0;
    sdi   <= tx[7];
    for (i = 7; i >= 0; i--) begin
      wait_clk(half);
      sclk <= 1'b1;
      wait_clk(1);
      #1 rx[i] = sdo;
      wait_clk(half - 1);
      sclk <= 1'b0;
      if (i > 0) begin
        sdi <= tx[i-1];
      end else begin
        sdi <= ~sdi;
      end
    end
    wait_clk(half);
    sen_n <= 1'b1;
  endtask

  // Clock pulses outside a frame; only used to show they are ignored.
  task automatic stray_clocks();
    repeat (8) begin
      wait_clk(4);
      sclk <= 1'b1;
      sdi  <= ~sdi;
      wait_clk(4);
      sclk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`include "mirror_ctrl_regs.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mirror_ctrl_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_b;
  reg_addr_t   reg_addr;
  reg_data_t   reg_wdata;
  reg_data_t   reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  driver_cmd_s pin_cmd;
  driver_cmd_s driver_cmd;
  logic        strobe;
  logic        oe_n;
  logic        clear_n;
  logic        sclk;
  logic        sdi;
  logic        sen_n;
  logic        sdo;
  logic        outputs_on;
  logic        offset_hold;
  logic        en_bias;
  logic        en_off;
  logic        en_neg;
  logic        irq_n;
  int          error_cnt;
  int          n_tests;
  int          i;
  logic [7:0]  rx;
  driver_cmd_s cmd_tab [3] = '{8'hA5, 8'h5A, 8'hFF};

  always #5 sys_clk = ~sys_clk;

  ctrl_model PEER (.clk(sys_clk), .cmd(pin_cmd), .strobe(strobe), .oe_n(oe_n), .clear_n(clear_n),
                   .sclk(sclk), .sdi(sdi), .sen_n(sen_n), .sdo(sdo));

  micromirror_reset_control_port DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .driver_address(pin_cmd.addr), .driver_mode(pin_cmd.mode),
    .driver_level_select(pin_cmd.level), .driver_strobe(strobe), .driver_output_enable_n(oe_n),
    .driver_clear_n(clear_n), .serial_port_clock(sclk), .serial_port_data_in(sdi),
    .serial_port_enable_n(sen_n), .serial_port_data_out(sdo), .driver_cmd(driver_cmd),
    .driver_outputs_on(outputs_on), .driver_offset_hold(offset_hold), .bias_supply_level_en(en_bias),
    .offset_supply_level_en(en_off), .negative_supply_level_en(en_neg), .driver_interrupt_n(irq_n));

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_write(input reg_addr_t a, input reg_data_t d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_check(input reg_addr_t a, input reg_data_t e, input string nm);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(nm, e, reg_rdata)
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_clk(4);
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("offset_hold", 1'b1, offset_hold)
    `CHK("outputs_on", 1'b0, outputs_on)
    `CHK("sdo", 1'b0, sdo)
    reg_check(4'hF, 16'h0000, "unmapped");
    $display("test reset done");
    for (i = 0; i < 3; i++) begin
      reg_write(`REG_CTRL, 16'h0001 << i);
      `CHK("enables", 3'(1 << i), {en_neg, en_off, en_bias})
      reg_check(`REG_CTRL, 16'h0001 << i, "ctrl");
    end
    reg_write(`REG_CTRL, 16'h0000);
    $display("test regulators done");
    reg_write(`REG_IRQ_ENABLE, 16'h0001);
    PEER.set_pins(1'b1, 1'b1);
    wait_clk(6);
    for (i = 0; i < 3; i++) begin
      PEER.send_cmd(cmd_tab[i]);
      #1 `CHK("driver_cmd", cmd_tab[i], driver_cmd)
      `CHK("irq_n", 1'b0, irq_n)
      reg_check(`REG_DRIVER, {8'h00, cmd_tab[i]}, "driver reg");
      reg_write(`REG_IRQ_CLEAR, 16'h0001);
      `CHK("irq_n", 1'b1, irq_n)
    end
    PEER.set_cmd(8'h00);
    wait_clk(8);
    `CHK("driver_cmd", 8'hFF, driver_cmd)
    $display("test strobe done");
    PEER.set_pins(1'b0, 1'b1);
    wait_clk(6);
    `CHK("outputs_on", 1'b1, outputs_on)
    reg_check(`REG_DRIVER, 16'h01FF, "driver reg");
    PEER.set_pins(1'b1, 1'b1);
    wait_clk(6);
    `CHK("outputs_on", 1'b0, outputs_on)
    $display("test output enable done");
    reg_write(`REG_IRQ_ENABLE, 16'h0002);
    PEER.set_pins(1'b0, 1'b0);
    wait_clk(6);
    `CHK("offset_hold", 1'b1, offset_hold)
    `CHK("driver_cmd", 8'h00, driver_cmd)
    `CHK("outputs_on", 1'b0, outputs_on)
    `CHK("irq_n", 1'b0, irq_n)
    reg_check(`REG_IRQ_STATUS, 16'h0002, "status");
    PEER.send_cmd(8'h3C);
    #1 `CHK("driver_cmd", 8'h00, driver_cmd)
    PEER.set_pins(1'b1, 1'b1);
    wait_clk(6);
    `CHK("offset_hold", 1'b0, offset_hold)
    reg_write(`REG_IRQ_CLEAR, 16'h0007);
    reg_write(`REG_IRQ_ENABLE, 16'h0004);
    $display("test clear done");
    reg_write(`REG_SERIAL_TX, 16'h00A5);
    PEER.xfer(8'h3C, 4, rx);
    `CHK("rx", 8'hA5, rx)
    wait_clk(4);
    `CHK("sdo", 1'b0, sdo)
    `CHK("irq_n", 1'b0, irq_n)
    reg_check(`REG_SERIAL_RX, 16'h003C, "serial rx");
    reg_write(`REG_SERIAL_TX, 16'h0081);
    // The clear is sampled on the same edge as the eighth bit, so the new word event must survive it.
    fork
      PEER.xfer(8'hC3, 4, rx);
      begin
        wait_clk(62);
        reg_write(`REG_IRQ_CLEAR, 16'h0004);
      end
    join
    `CHK("rx", 8'h81, rx)
    reg_check(`REG_IRQ_STATUS, 16'h0004, "set wins");
    reg_check(`REG_SERIAL_RX, 16'h00C3, "serial rx");
    reg_write(`REG_IRQ_CLEAR, 16'h0007);
    PEER.stray_clocks();
    wait_clk(4);
    reg_check(`REG_SERIAL_RX, 16'h00C3, "serial rx");
    reg_check(`REG_IRQ_STATUS, 16'h0000, "status");
    `CHK("irq_n", 1'b1, irq_n)
    $display("test serial done");
    reg_write(`REG_IRQ_STATUS, 16'h0007);
    reg_check(`REG_IRQ_STATUS, 16'h0000, "status ro");
    reg_check(`REG_IRQ_ENABLE, 16'h0004, "enable");
    $display("test register access done");
    complete_run();
  end
endmodule
`default_nettype wire
